// ==== design/tosm_pkg.sv ====
package tosm_pkg;

    // ****************************************
    // Sizes and timing
    // ****************************************
    localparam int NSTR = 2;
    localparam int NDRV = 8;
    localparam int CNT_W = 32;
    localparam int CLK_MHZ = 100;
    localparam int T_LOW_US = 300;
    localparam int LOW_CYC = T_LOW_US * CLK_MHZ;
    localparam int T_GAP_MS = 200;
    localparam int GAP_CYC = T_GAP_MS * 1000 * CLK_MHZ;
    localparam int T_REACT_MS = 10;
    localparam int REACT_CYC = T_REACT_MS * 1000 * CLK_MHZ;
    localparam int T_BOOT_MS = 100;
    localparam int BOOT_CYC = T_BOOT_MS * 1000 * CLK_MHZ;
    localparam int T_DWELL_MS = 500;
    localparam int DWELL_CYC = T_DWELL_MS * 1000 * CLK_MHZ;

    // ****************************************
    // Register map and fields
    // ****************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STAT = 12'h004;
    localparam logic [11:0] OFF_DISP = 12'h008;
    localparam logic [11:0] OFF_NADDR = 12'h00c;
    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_FCLR_BIT = 4;
    localparam int STAT_IND_LSB = 0;
    localparam int STAT_REL_LSB = 2;
    localparam int STAT_FLT_LSB = 4;
    localparam int STAT_BOOT_BIT = 6;
    localparam int DISP_FCODE_LSB = 0;
    localparam int DISP_FVALID_BIT = 8;
    localparam int DISP_FKIND_BIT = 9;
    localparam int DISP_WCODE_LSB = 16;
    localparam int DISP_WVALID_BIT = 24;
    localparam logic [31:0] REG_RST = 32'h0000_0000;

    // ****************************************
    // Display glyphs, segments g..a
    // ****************************************
    localparam logic [7:0] SEG_F = 8'h71;
    localparam logic [7:0] SEG_E = 8'h79;
    localparam logic [7:0] SEG_N = 8'h54;
    localparam logic [7:0] SEG_DASH = 8'h40;
    localparam logic [7:0] SEG_OFF = 8'h00;
    localparam logic [3:0] ADDR_NIB = 4'h8;
    localparam logic [3:0] CODE_PH = 4'h3;

    // Per-string drive status as reported by the drives
    typedef struct packed {
        logic [NDRV-1:0] present;
        logic [NDRV-1:0] torque_off;
        logic [NDRV-1:0] comm_ok;
        logic [NDRV-1:0] local_opt;
    } tosm_drv_t;

    // Hex digit to seven-segment pattern
    function automatic logic [7:0] tosm_hex_seg(input logic [3:0] n);
        logic [7:0] s;
        case (n)
            4'h0: s = 8'h3f;
            4'h1: s = 8'h06;
            4'h2: s = 8'h5b;
            4'h3: s = 8'h4f;
            4'h4: s = 8'h66;
            4'h5: s = 8'h6d;
            4'h6: s = 8'h7d;
            4'h7: s = 8'h07;
            4'h8: s = 8'h7f;
            4'h9: s = 8'h6f;
            4'ha: s = 8'h77;
            4'hb: s = 8'h7c;
            4'hc: s = 8'h39;
            4'hd: s = 8'h5e;
            4'he: s = 8'h79;
            default: s = 8'h71;
        endcase
        return s;
    endfunction

endpackage

// ==== design/tosm_pulse_filter.sv ====
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Test-pulse filter for one release input
// ****************************************
module tosm_pulse_filter #(
    parameter logic [31:0] LOW_CYC = 32'(tosm_pkg::LOW_CYC),
    parameter logic [31:0] GAP_CYC = 32'(tosm_pkg::GAP_CYC)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic raw_in,
    output logic release_o
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic [31:0] low;
        logic [31:0] gap;
        logic gap_ok;
        logic hold;
        logic rel;
    } tosm_flt_st_t;

    tosm_flt_st_t q, d;

    // Width and spacing measured on the synchronised level
    always_comb begin
        d = q;
        d.s1 = raw_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s3 && !q.s2) begin
            d.gap = '0;
            d.gap_ok = 1'b0;
            if (!q.gap_ok) begin
                d.hold = 1'b1;
                d.rel = 1'b0;
            end
        end else if (q.gap < GAP_CYC) begin
            d.gap = q.gap + 32'h1;
            // Sticky so the reset value lets a first pulse through
            d.gap_ok = q.gap_ok || ((q.gap + 32'h1) >= GAP_CYC);
        end
        if (!q.s2) begin
            // Trip within 300 us, far inside the 10 ms budget
            if (q.low < LOW_CYC) begin
                d.low = q.low + 32'h1;
            end
            if ((q.low + 32'h1) >= LOW_CYC) begin
                d.rel = 1'b0;
            end
        end else begin
            d.low = '0;
            if (q.hold && q.gap_ok) begin
                d.hold = 1'b0;
            end
            // Short pulse never reached the width limit
            d.rel = !(q.hold && !q.gap_ok);
        end
    end

    // Starts released-off until the input is seen high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{s1: 1'b0, s2: 1'b0, s3: 1'b0, low: 32'h0,
                   gap: 32'h0, gap_ok: 1'b1, hold: 1'b0, rel: 1'b0};
        end else if (ce) begin
            q <= d;
        end
    end

    assign release_o = q.rel;

endmodule

`default_nettype wire

// ==== design/tosm_top.sv ====
// Behaviour
// - One release input and one indication per string; each acts on its string only.
// - Input high releases power stages of that string's drives without local option.
// - Input falling withdraws power-stage release; drives coast down.
// - Drives with local safety option ignore the string release input.
// - Local-option drives still feed their status into the string indication.
// - Indication is the OR of all connected drives' torque-off bits.
// - Indication is high during boot after power-up.
// - Indication is high while the string release input is low.
// - Indication high on lost drive link, empty string or local bus failure.
// - Torque only with string enable set, and release input high for drives without local option.
// - Release high and no forcing cause gives low indication, any enable.
// - Low test pulses under 300 us spaced over 200 ms are ignored.
// - Pulses outside width or spacing trip torque-off like a real removal.
// - Torque-off while enabled opens the fault contact.
// - Enabling a string is refused while its torque-off is active.
// - Display shows fault codes with F or E, warnings with n.
// - Display shows device state once supply is on.
// - Address-show button flashes the network address on the display.
// - Release input fall to energy removal is at most 10 ms.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

module tosm_top #(
    parameter logic [31:0] LOW_CYC = 32'(tosm_pkg::LOW_CYC),
    parameter logic [31:0] GAP_CYC = 32'(tosm_pkg::GAP_CYC),
    parameter logic [31:0] BOOT_CYC = 32'(tosm_pkg::BOOT_CYC),
    parameter logic [31:0] DWELL_CYC = 32'(tosm_pkg::DWELL_CYC)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] torque_release_input,
    input wire tosm_pkg::tosm_drv_t [1:0] drv,
    input wire logic fieldbus_ok,
    input wire logic address_show_button,
    output logic [1:0] torque_off_indication,
    output logic [1:0][7:0] power_stage_release,
    output logic fault_contact_open,
    output logic [7:0] disp_seg
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [1:0] en;
        logic [1:0] fault;
        logic [1:0] rel_prev;
        logic [31:0] boot_cnt;
        logic booting;
        logic [1:0] ind;
        logic [1:0][7:0] pwr;
        logic fcontact;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [31:0] disp_cfg;
        logic [31:0] naddr;
        logic [31:0] dwell;
        logic [3:0] phase;
        logic addr_mode;
        logic btn_prev;
        logic [7:0] seg;
    } tosm_top_st_t;

    tosm_top_st_t q, d;
    logic [1:0] rel;

    // Register decode shared by read and write
    function automatic logic addr_hit(input logic [31:0] a);
        logic [11:0] o;
        o = a[11:0];
        return (a[31:12] == 20'h0) &&
               (o == tosm_pkg::OFF_CTRL || o == tosm_pkg::OFF_STAT ||
                o == tosm_pkg::OFF_DISP || o == tosm_pkg::OFF_NADDR);
    endfunction

    // ****************************************
    // Input filters, one per string
    // ****************************************
    for (genvar i = 0; i < tosm_pkg::NSTR; i++) begin : g_flt
        tosm_pulse_filter #(
            .LOW_CYC(LOW_CYC),
            .GAP_CYC(GAP_CYC)
        ) u_flt (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .raw_in(torque_release_input[i]),
            .release_o(rel[i])
        );
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        logic setup;
        logic acc;
        logic wr;
        logic [11:0] off;
        logic [1:0] toff;
        logic [1:0] drop;
        logic [31:0] rd;
        logic fvalid;
        logic wvalid;
        logic [7:0] code;
        logic [7:0] pre;
        logic [3:0] nib;
        logic [3:0] last_ph;
        setup = psel && !penable;
        acc = psel && penable && q.pready;
        wr = acc && pwrite && addr_hit(paddr);
        off = paddr[11:0];
        toff = '0;
        drop = '0;
        rd = '0;
        fvalid = q.disp_cfg[tosm_pkg::DISP_FVALID_BIT];
        wvalid = q.disp_cfg[tosm_pkg::DISP_WVALID_BIT];
        code = '0;
        pre = tosm_pkg::SEG_OFF;
        nib = '0;
        last_ph = '0;
        d = q;

        // Boot window after reset release
        if (q.booting) begin
            if ((q.boot_cnt + 32'h1) >= BOOT_CYC) begin
                d.booting = 1'b0;
            end
            d.boot_cnt = q.boot_cnt + 32'h1;
        end

        // Per-string torque logic
        for (int i = 0; i < tosm_pkg::NSTR; i++) begin
            toff[i] = q.booting || !rel[i];
            drop[i] = q.rel_prev[i] && !rel[i];
            d.rel_prev[i] = rel[i];
            if (drop[i] && q.en[i]) begin
                d.fault[i] = 1'b1;
            end else if (wr && off == tosm_pkg::OFF_CTRL &&
                         pwdata[tosm_pkg::CTRL_FCLR_BIT]) begin
                d.fault[i] = 1'b0;
            end
            // Enable survives torque-off so local-option drives keep running
            if (wr && off == tosm_pkg::OFF_CTRL) begin
                d.en[i] = pwdata[tosm_pkg::CTRL_EN_LSB + i] && !toff[i];
            end
            d.ind[i] = q.booting ||
                       !rel[i] ||
                       (|(drv[i].present & drv[i].torque_off)) ||
                       (|(drv[i].present & ~drv[i].comm_ok)) ||
                       !(|drv[i].present) ||
                       !fieldbus_ok;
            for (int j = 0; j < tosm_pkg::NDRV; j++) begin
                // Local-option drives skip the string input
                d.pwr[i][j] = !q.booting && q.en[i] && !toff[i] &&
                              drv[i].present[j] && !drv[i].local_opt[j];
                if (drv[i].local_opt[j]) begin
                    d.pwr[i][j] = !q.booting && q.en[i] && drv[i].present[j];
                end
            end
        end
        d.fcontact = |d.fault;

        // Register writes
        if (wr && off == tosm_pkg::OFF_DISP) begin
            d.disp_cfg = pwdata;
        end
        if (wr && off == tosm_pkg::OFF_NADDR) begin
            d.naddr = pwdata;
        end

        // Read data captured in setup so it stands through access
        case (off)
            tosm_pkg::OFF_CTRL: rd[1:0] = q.en;
            tosm_pkg::OFF_STAT: begin
                rd[tosm_pkg::STAT_IND_LSB +: 2] = q.ind;
                rd[tosm_pkg::STAT_REL_LSB +: 2] = rel;
                rd[tosm_pkg::STAT_FLT_LSB +: 2] = q.fault;
                rd[tosm_pkg::STAT_BOOT_BIT] = q.booting;
            end
            tosm_pkg::OFF_DISP: rd = q.disp_cfg;
            tosm_pkg::OFF_NADDR: rd = q.naddr;
            default: rd = '0;
        endcase
        d.pready = setup;
        d.pslverr = setup && !addr_hit(paddr);
        if (setup) begin
            d.prdata = addr_hit(paddr) ? rd : '0;
        end

        // ****************************************
        // Status display
        // ****************************************
        d.btn_prev = address_show_button;
        last_ph = q.addr_mode ? tosm_pkg::ADDR_NIB - 4'h1 : tosm_pkg::CODE_PH - 4'h1;
        if (address_show_button && !q.btn_prev) begin
            d.addr_mode = 1'b1;
            d.phase = '0;
            d.dwell = '0;
        end else if ((q.dwell + 32'h1) >= DWELL_CYC) begin
            d.dwell = '0;
            if (q.phase >= last_ph) begin
                d.phase = '0;
                d.addr_mode = 1'b0;
            end else begin
                d.phase = q.phase + 4'h1;
            end
        end else begin
            d.dwell = q.dwell + 32'h1;
        end

        // Fault beats warning; both repeat while present
        if (fvalid) begin
            code = q.disp_cfg[tosm_pkg::DISP_FCODE_LSB +: 8];
            pre = q.disp_cfg[tosm_pkg::DISP_FKIND_BIT] ? tosm_pkg::SEG_E
                                                       : tosm_pkg::SEG_F;
        end else if (wvalid) begin
            code = q.disp_cfg[tosm_pkg::DISP_WCODE_LSB +: 8];
            pre = tosm_pkg::SEG_N;
        end
        if (q.addr_mode) begin
            // Most significant nibble first, one per dwell
            nib = q.naddr[5'(28 - 4 * int'(q.phase)) +: 4];
            d.seg = tosm_pkg::tosm_hex_seg(nib);
        end else if (fvalid || wvalid) begin
            case (q.phase)
                4'h0: d.seg = pre;
                4'h1: d.seg = tosm_pkg::tosm_hex_seg(code[7:4]);
                default: d.seg = tosm_pkg::tosm_hex_seg(code[3:0]);
            endcase
        end else if (q.booting) begin
            d.seg = tosm_pkg::SEG_DASH;
        end else begin
            d.seg = tosm_pkg::tosm_hex_seg({2'b00, q.ind});
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // Indication comes up forced and the contact closed; nothing is released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{en: 2'b00, fault: 2'b00, rel_prev: 2'b00,
                   boot_cnt: 32'h0, booting: 1'b1, ind: 2'b11,
                   pwr: 16'h0000, fcontact: 1'b0, pready: 1'b0,
                   pslverr: 1'b0, prdata: 32'h0,
                   disp_cfg: tosm_pkg::REG_RST,
                   naddr: tosm_pkg::REG_RST, dwell: 32'h0,
                   phase: 4'h0, addr_mode: 1'b0, btn_prev: 1'b0,
                   seg: tosm_pkg::SEG_OFF};
        end else if (ce) begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs, all from flip-flops
    // ****************************************
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign torque_off_indication = q.ind;
    assign power_stage_release = q.pwr;
    assign fault_contact_open = q.fcontact;
    assign disp_seg = q.seg;

endmodule

`default_nettype wire

// ==== sim/tosm_safety_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Safety controller model, one output per string
// ****************************************
module tosm_safety_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] hold_low,
    input wire logic [1:0] pulse_go,
    input wire logic [15:0] pulse_w,
    output logic [1:0] torque_release_input
);
    logic [1:0][15:0] left_q;

    // Test pulse length counter; a new request restarts the pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_q <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (pulse_go[i]) begin
                    left_q[i] <= pulse_w;
                end else if (left_q[i] != 16'h0000) begin
                    left_q[i] <= left_q[i] - 16'h0001;
                end
            end
        end
    end

    // Output drops while held off or while a test pulse runs
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            torque_release_input[i] = !hold_low[i] && left_q[i] == 16'h0000;
        end
    end
endmodule
`default_nettype wire

// ==== sim/tosm_top_properties.sv ====
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Port checker for the string monitor
// ****************************************
module tosm_top_properties #(
    parameter logic [31:0] LOW_CYC = 32'd30,
    parameter logic [31:0] GAP_CYC = 32'd200,
    parameter logic [31:0] BOOT_CYC = 32'd20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] torque_release_input,
    input wire tosm_pkg::tosm_drv_t [1:0] drv,
    input wire logic fieldbus_ok,
    input wire logic [1:0] torque_off_indication,
    input wire logic [1:0][7:0] power_stage_release
);
    logic [15:0] cyc_q;
    logic [1:0][15:0] low_q, high_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Run lengths saturate so long idle spans never wrap round
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_q <= '0;
            low_q <= '0;
            high_q <= '0;
        end else begin
            cyc_q <= cyc_q + {15'h0, cyc_q != 16'hffff};
            for (int i = 0; i < 2; i++) begin
                low_q[i] <= torque_release_input[i] ? '0 : low_q[i] + {15'h0, low_q[i] != '1};
                high_q[i] <= !torque_release_input[i] ? '0 : high_q[i] + {15'h0, high_q[i] != '1};
            end
        end
    end

    a_boot_forced: assert property (32'(cyc_q) < BOOT_CYC |-> torque_off_indication == 2'b11)
        else $error("indication low during boot");
    a_boot_no_pwr: assert property (32'(cyc_q) < BOOT_CYC |-> power_stage_release == '0)
        else $error("power stage released during boot");
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");

    for (genvar i = 0; i < 2; i++) begin : g_str
        a_rel_trips: assert property (
            32'(low_q[i]) >= LOW_CYC + 32'd6 |-> torque_off_indication[i])
            else $error("long low input did not force indication");
        a_rel_no_pwr: assert property (
            32'(low_q[i]) >= LOW_CYC + 32'd6 && $stable(drv[i].local_opt)
            |-> (power_stage_release[i] & ~drv[i].local_opt) == 8'h00)
            else $error("power stage kept without release input");
        a_present_pwr: assert property (
            $stable(drv[i].present) [*3] |-> (power_stage_release[i] & ~drv[i].present) == 8'h00)
            else $error("absent drive released");
        a_drv_or: assert property (
            (|(drv[i].present & drv[i].torque_off)) [*3] |-> torque_off_indication[i])
            else $error("drive status missing from indication");
        a_cause_forces: assert property (
            (!fieldbus_ok || drv[i].present == 8'h00 || |(drv[i].present & ~drv[i].comm_ok)) [*3]
            |-> torque_off_indication[i])
            else $error("link or bus fault did not force indication");
        a_ind_clear: assert property (
            (32'(high_q[i]) > GAP_CYC + 32'd6 && 32'(cyc_q) > BOOT_CYC + 32'd6 && fieldbus_ok
            && drv[i].present != 8'h00
            && (drv[i].present & (drv[i].torque_off | ~drv[i].comm_ok)) == 8'h00) [*3]
            |-> !torque_off_indication[i])
            else $error("indication high without cause");
    end
endmodule

bind tosm_top tosm_top_properties #(
    .LOW_CYC(LOW_CYC),
    .GAP_CYC(GAP_CYC),
    .BOOT_CYC(BOOT_CYC)
) tosm_top_properties_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .torque_release_input(torque_release_input), .drv(drv),
    .fieldbus_ok(fieldbus_ok), .torque_off_indication(torque_off_indication),
    .power_stage_release(power_stage_release)
);
`default_nettype wire

// ==== sim/tosm_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module tosm_top_tb;
    localparam int LOW = 30;
    localparam int GAP = 200;
    localparam logic [31:0] DISP_V [3] = '{32'h0000_0312, 32'h0000_0112, 32'h0134_0000};
    localparam logic [7:0] DISP_S [3] = '{tosm_pkg::SEG_E, tosm_pkg::SEG_F, tosm_pkg::SEG_N};
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, fieldbus_ok, btn, fopen, er;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [1:0] trel, ind, hold_low, pulse_go;
    logic [1:0][7:0] pwr;
    logic [7:0] seg;
    tosm_pkg::tosm_drv_t [1:0] drv;
    int err_count, n_tests;

    // ****************************************
    // Design and far side
    // ****************************************
    tosm_top #(.LOW_CYC(32'(LOW)), .GAP_CYC(32'(GAP)), .BOOT_CYC(32'd20), .DWELL_CYC(32'd4))
    tosm_top_i (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .torque_release_input(trel), .drv(drv), .fieldbus_ok(fieldbus_ok),
        .address_show_button(btn), .torque_off_indication(ind), .power_stage_release(pwr),
        .fault_contact_open(fopen), .disp_seg(seg)
    );
    tosm_safety_ctrl tosm_safety_ctrl_i (.pclk(pclk), .presetn(presetn), .hold_low(hold_low),
        .pulse_go(pulse_go), .pulse_w(16'(LOW - 10)), .torque_release_input(trel));

    always #5 pclk = ~pclk;

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", s, e, g);
        end
    endtask

    // Master holds the request until ready is seen; any wait cycle counts as a mismatch
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        check("apb waits", 32'd0, 32'(n));
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string s);
        apb(1'b0, a, 32'h0);
        check(s, e, rd);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic pulse(input int i);
        @(posedge pclk);
        pulse_go[i] <= 1'b1;
        @(posedge pclk);
        pulse_go[i] <= 1'b0;
    endtask

    task automatic wait_seg(input logic [7:0] v);
        int n;
        n = 0;
        @(negedge pclk);
        while (seg !== v && n < 80) begin
            n++;
            @(negedge pclk);
        end
        check("display", 32'(v), 32'(seg));
    endtask

    task automatic good();
        for (int i = 0; i < 2; i++) begin
            drv[i] <= '{8'($urandom) | 8'h01, 8'h00, 8'hff, 8'($urandom)};
        end
        fieldbus_ok <= 1'b1;
    endtask

    // Any present drive off, unreachable, none present or bus down forces the string
    function automatic logic exp_ind(input tosm_pkg::tosm_drv_t d, input logic fb);
        return !fb || d.present == 8'h00 || |(d.present & (d.torque_off | ~d.comm_ok));
    endfunction

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        {pclk, presetn, psel, penable, pwrite, btn, hold_low, pulse_go, paddr, pwdata} = '0;
        ce = 1'b1;
        drv = '0;
        err_count = 0;
        n_tests = 0;
        void'($urandom(32'hf4cf));
        good();
        settle(19);
        check("reset ind", 32'd3, 32'(ind));
        @(posedge pclk);
        presetn <= 1'b1;
        settle(4);
        check("boot ind", 32'd3, 32'(ind));
        check("boot display", 32'h40, 32'(seg));
        $display("test boot done");
        settle(GAP);
        apb(1'b1, 32'hc, 32'h1111_1111);
        rd_chk(32'hc, 32'h1111_1111, "address reg");
        apb(1'b0, 32'h10, 32'h0);
        check("unmapped", 32'h1, {rd[30:0], er});
        apb(1'b1, 32'h6, 32'hffff_ffff);
        check("unaligned", 32'h1, 32'(er));
        check("idle ind", 32'd0, 32'(ind));
        apb(1'b1, 32'h0, 32'h3);
        rd_chk(32'h0, 32'h3, "enable");
        settle(2);
        check("release", 32'({drv[1].present, drv[0].present}), 32'(pwr));
        $display("test registers done");
        pulse(0);
        settle(40);
        check("pulse ind", 32'd0, 32'(ind));
        check("pulse release", 32'({drv[1].present, drv[0].present}), 32'(pwr));
        pulse(0);
        settle(12);
        check("gap ind", 32'd1, 32'(ind));
        // Local-option drives on the tripped string keep their release
        check("gap release", 32'({drv[1].present, drv[0].present & drv[0].local_opt}),
              32'(pwr));
        check("fault contact", 32'd1, 32'(fopen));
        apb(1'b1, 32'h0, 32'h3);
        rd_chk(32'h0, 32'h2, "refused enable");
        settle(GAP + 20);
        apb(1'b1, 32'h0, 32'h12);
        rd_chk(32'h4, 32'hc, "status");
        check("contact closed", 32'd0, 32'(fopen));
        apb(1'b1, 32'h0, 32'h3);
        apb(1'b1, 32'h0, 32'h1);
        @(posedge pclk);
        hold_low[1] <= 1'b1;
        settle(LOW + 12);
        check("removal ind", 32'd2, 32'(ind));
        check("removal release", 32'd0, 32'(pwr[1]));
        check("no fault", 32'd0, 32'(fopen));
        apb(1'b1, 32'h0, 32'h3);
        rd_chk(32'h0, 32'h1, "held enable");
        @(posedge pclk);
        hold_low[1] <= 1'b0;
        settle(GAP + 20);
        apb(1'b1, 32'h0, 32'h3);
        $display("test torque off done");
        for (int k = 0; k < 12; k++) begin
            @(posedge pclk);
            for (int i = 0; i < 2; i++) begin
                drv[i].present <= ($urandom % 6 == 0) ? 8'h00 : 8'($urandom);
                drv[i].torque_off <= 8'($urandom & $urandom & $urandom);
                drv[i].comm_ok <= ~8'($urandom & $urandom & $urandom);
                drv[i].local_opt <= 8'($urandom);
            end
            fieldbus_ok <= ($urandom % 5 != 0);
            settle(6);
            for (int i = 0; i < 2; i++) begin
                check("drive ind", 32'(exp_ind(drv[i], fieldbus_ok)), 32'(ind[i]));
                check("drive release", 32'(drv[i].present), 32'(pwr[i]));
            end
        end
        @(posedge pclk);
        good();
        $display("test random drives done");
        @(posedge pclk);
        btn <= 1'b1;
        @(posedge pclk);
        btn <= 1'b0;
        wait_seg(8'h06);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, 32'h8, DISP_V[k]);
            wait_seg(DISP_S[k]);
        end
        $display("test display done");
        conclude();
    end

    // Cuts a hang short well beyond the expected run length
    initial begin
        repeat (5000) @(posedge pclk);
        err_count++;
        $display("unexpected watchdog: expected end, seen none");
        conclude();
    end
endmodule
`default_nettype wire
